// >>> core/adc_trig_pkg.sv
// Types used by the trigger sequencer; its interval timer uses none of them.
// Assumes the constants header is included by the design files.
package adc_trig_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    st_idle,
    st_armed,
    st_lag,
    st_convert,
    st_gap,
    st_done
  } seq_state_e;

  // Software-written configuration carried as one bundle
  typedef struct packed {
    logic       on;
    logic       ext;
    logic       rising;
    logic       holdoff;
    logic       repeat_on;
    logic [2:0] mode;
    logic [3:0] lag;
    logic [3:0] gap;
  } cfg_s;

  // Converter handshake and result
  typedef struct packed {
    logic       done;
    logic [9:0] data;
  } conv_s;

endpackage

// >>> core/adc_trig_regs.svh
// Offsets, field positions, reset values and timing counts of the
// conversion trigger sequencer. Definitions only; no logic here.
`ifndef ADC_TRIG_REGS_SVH
`define ADC_TRIG_REGS_SVH

// Register word offsets on the plain port (byte-free index)
`define OFS_CONTROL      4'h0
`define OFS_TIMING       4'h1
`define OFS_HIGH_A       4'h2
`define OFS_HIGH_B       4'h3
`define OFS_LOW_A        4'h4
`define OFS_LOW_B        4'h5
`define OFS_STATUS       4'h6
`define OFS_SAMPLE       4'h7
`define OFS_RESULT       4'h8

// Control register fields
`define CTL_ON           0
`define CTL_EXT          1
`define CTL_EDGE         2
`define CTL_HOLDOFF      3
`define CTL_REPEAT       4
`define CTL_MODE_LSB     5
`define CTL_MODE_MSB     7

// Timing register fields: lag code [3:0], gap code [7:4]
`define TIM_LAG_LSB      0
`define TIM_LAG_MSB      3
`define TIM_GAP_LSB      4
`define TIM_GAP_MSB      7

// Reset values
`define CONTROL_RST      8'h00
`define TIMING_RST       8'h00
`define HIGH_RST         8'hff
`define LOW_RST          8'h00

// Timing: 25 MHz clock, one lag or gap step is 50 us
`define CLK_MHZ          25
`define STEP_US          50
`define STEP_CYCLES      (`STEP_US * `CLK_MHZ)
`define LAG_MAX_US       750
`define CONV_CYCLES      16'h0040

`endif

// >>> core/adc_trigger_sequencer.sv
// Trigger and sample sequencer for an eight-channel monitoring converter.
// Assumes a converter that takes a start pulse and returns done plus data.
// Operation
// - Trigger pin edge, polarity selectable, starts conversion
// - Armed external mode waits for trigger indefinitely
// - Programmable lag zero to 750 us
// - Start only if pin still active
// - Gap timed from conversion end to start
// - Holdoff off: whole cycle runs after first
// - Holdoff off: later edges ignored until done
// - Holdoff on: each sample needs edge, level
// - Out-of-limit result ends cycle early
// - Limit break raises interrupt and done
// - Repeat mode restarts cycle on completion
// - All trigger modes work in repeat
// - Repeat mode gives no per-cycle done
// - Repeat interrupt only signals limit break
// - External exit: leave ext, clear repeat
// - Cycle starts only on enable rising write
// - Samples per cycle from 1 to 256
`timescale 1ns/1ps
`include "adc_trig_regs.svh"

module adc_trigger_sequencer #(
  parameter int TW = 16                  // Interval counter width
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // Trigger pin
  input  wire logic        trigger_input_pin,
  // Converter engine
  output logic             conv_start,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_data,
  // Host alert and status
  output logic             host_irq,
  output logic             conversion_status
);

  ////////////////////////////////////////////////////////////////////
  // Register file
  ////////////////////////////////////////////////////////////////////
  logic [7:0] control;           // On, ext, edge, holdoff, repeat, mode
  logic [7:0] timing;            // Lag and gap codes
  logic [7:0] high_limit_reg_a;  // Upper limit, low byte
  logic [7:0] high_limit_reg_b;  // Upper limit, top bits
  logic [7:0] low_limit_reg_a;   // Lower limit, low byte
  logic [7:0] low_limit_reg_b;   // Lower limit, top bits
  logic [7:0] next_control, next_timing;
  logic [7:0] next_hia, next_hib, next_loa, next_lob;
  logic [7:0] next_rdata;
  adc_trig_pkg::cfg_s cfg;

  // Unpack the control bits into one bundle
  always_comb begin
    cfg.on        = control[`CTL_ON];
    cfg.ext       = control[`CTL_EXT];
    cfg.rising    = control[`CTL_EDGE];
    cfg.holdoff   = control[`CTL_HOLDOFF];
    cfg.repeat_on = control[`CTL_REPEAT];
    cfg.mode      = control[`CTL_MODE_MSB:`CTL_MODE_LSB];
    cfg.lag       = timing[`TIM_LAG_MSB:`TIM_LAG_LSB];
    cfg.gap       = timing[`TIM_GAP_MSB:`TIM_GAP_LSB];
  end

  // Samples per cycle: 1,4,8,...,256 from the mode code
  function automatic logic [8:0] samples_of(input logic [2:0] m);
    samples_of = (m == 3'h0) ? 9'h001 : 9'((9'h002) << m);
  endfunction

  // Interval code to cycles; code 15 gives 750 us
  function automatic logic [TW-1:0] cycles_of(input logic [3:0] c);
    logic [TW-1:0] k;
    k = TW'(c);
    cycles_of = TW'(k * `STEP_CYCLES);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Trigger synchroniser and edge detect
  ////////////////////////////////////////////////////////////////////
  logic sync_a, sync_b, sync_c;  // Two flops then an edge history flop

  // Pin into the clock domain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else if (ce) begin
      sync_a <= trigger_input_pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  logic pin_active, edge_seen;
  // Active level follows the chosen edge
  assign pin_active = cfg.rising ? sync_b : !sync_b;
  assign edge_seen  = cfg.rising ? (sync_b && !sync_c)
                                 : (!sync_b && sync_c);

  ////////////////////////////////////////////////////////////////////
  // Interval timer
  ////////////////////////////////////////////////////////////////////
  logic          tmr_load, tmr_exp;
  logic [TW-1:0] tmr_count;

  interval_timer #(.WIDTH(TW)) u_timer (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .load    (tmr_load),
    .count   (tmr_count),
    .expired (tmr_exp)
  );

  ////////////////////////////////////////////////////////////////////
  // Sequencer
  ////////////////////////////////////////////////////////////////////
  adc_trig_pkg::seq_state_e state, next_state;
  logic [8:0] taken, next_taken;      // Samples converted this cycle
  logic       on_q, next_on_q;        // Previous enable, for rising write
  logic       busy, next_busy;        // Cycle in progress
  logic       irq, next_irq;          // Host alert level
  logic       start, next_start;      // Converter start pulse
  logic       oor, next_oor;          // Last cycle broke a limit
  logic [9:0] result, next_result;    // Last sample
  logic [9:0] hi_lim, lo_lim;
  logic       arm;

  assign hi_lim = {high_limit_reg_b[1:0], high_limit_reg_a};
  assign lo_lim = {low_limit_reg_b[1:0], low_limit_reg_a};
  assign arm    = cfg.on && !on_q;

  // Next state of the sequence
  always_comb begin
    next_state  = state;
    next_taken  = taken;
    next_on_q   = cfg.on;
    next_busy   = busy;
    next_irq    = irq;
    next_start  = 1'b0;
    next_oor    = oor;
    next_result = result;
    tmr_load    = 1'b0;
    tmr_count   = cycles_of(cfg.lag);
    // A status read acknowledges the host alert; a set below wins
    if (rd && addr == `OFS_STATUS) begin
      next_irq = 1'b0;
    end
    case (state)
      adc_trig_pkg::st_idle: begin
        if (arm) begin
          next_busy  = 1'b1;
          next_taken = '0;
          next_oor   = 1'b0;
          next_state = adc_trig_pkg::st_armed;
        end
      end
      adc_trig_pkg::st_armed: begin
        // Waits forever for an edge in external mode
        if (!cfg.ext) begin
          next_start = 1'b1;
          next_state = adc_trig_pkg::st_convert;
        end else if (edge_seen) begin
          tmr_load   = 1'b1;
          next_state = adc_trig_pkg::st_lag;
        end
      end
      adc_trig_pkg::st_lag: begin
        if (tmr_exp) begin
          if (pin_active) begin
            next_start = 1'b1;
            next_state = adc_trig_pkg::st_convert;
          end else begin
            next_state = adc_trig_pkg::st_armed;
          end
        end
      end
      adc_trig_pkg::st_convert: begin
        if (conv_done) begin
          next_result = conv_data;
          next_taken  = taken + 9'h001;
          if (conv_data > hi_lim || conv_data < lo_lim) begin
            next_oor   = 1'b1;
            next_irq   = 1'b1;
            next_state = adc_trig_pkg::st_done;
          end else if (taken + 9'h001 >= samples_of(cfg.mode)) begin
            next_state = adc_trig_pkg::st_done;
          end else begin
            tmr_load   = 1'b1;
            tmr_count  = cycles_of(cfg.gap);
            next_state = adc_trig_pkg::st_gap;
          end
        end
      end
      adc_trig_pkg::st_gap: begin
        // Holdoff needs a fresh edge and active level; else free-run
        if (tmr_exp) begin
          if (!cfg.ext || !cfg.holdoff) begin
            next_start = 1'b1;
            next_state = adc_trig_pkg::st_convert;
          end else begin
            next_state = adc_trig_pkg::st_armed;
          end
        end
      end
      adc_trig_pkg::st_done: begin
        // Repeat restarts at once unless oor; else done, alert set here only without repeat
        if (cfg.repeat_on && !oor) begin
          next_taken = '0;
          next_state = adc_trig_pkg::st_armed;
        end else begin
          next_busy = 1'b0;
          if (!cfg.repeat_on) begin
            next_irq = 1'b1;
          end
          next_state = adc_trig_pkg::st_idle;
        end
      end
      default: next_state = adc_trig_pkg::st_idle;
    endcase
  end

  // Register writes and read mux
  always_comb begin
    next_control = control;
    next_timing  = timing;
    next_hia     = high_limit_reg_a;
    next_hib     = high_limit_reg_b;
    next_loa     = low_limit_reg_a;
    next_lob     = low_limit_reg_b;
    if (wr) begin
      case (addr)
        `OFS_CONTROL: next_control = wdata;
        `OFS_TIMING:  next_timing  = wdata;
        `OFS_HIGH_A:  next_hia     = wdata;
        `OFS_HIGH_B:  next_hib     = wdata;
        `OFS_LOW_A:   next_loa     = wdata;
        `OFS_LOW_B:   next_lob     = wdata;
        default:      ;
      endcase
    end
    next_rdata = 8'h00;
    if (rd) begin
      case (addr)
        `OFS_CONTROL: next_rdata = control;
        `OFS_TIMING:  next_rdata = timing;
        `OFS_HIGH_A:  next_rdata = high_limit_reg_a;
        `OFS_HIGH_B:  next_rdata = high_limit_reg_b;
        `OFS_LOW_A:   next_rdata = low_limit_reg_a;
        `OFS_LOW_B:   next_rdata = low_limit_reg_b;
        `OFS_STATUS:  next_rdata = {5'h00, oor, irq, busy};
        `OFS_SAMPLE:  next_rdata = taken[7:0];
        `OFS_RESULT:  next_rdata = result[9:2];
        default:      next_rdata = 8'h00;  // Unmapped reads zero
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control          <= `CONTROL_RST;
      timing           <= `TIMING_RST;
      high_limit_reg_a <= `HIGH_RST;
      high_limit_reg_b <= `HIGH_RST;
      low_limit_reg_a  <= `LOW_RST;
      low_limit_reg_b  <= `LOW_RST;
      rdata            <= 8'h00;
      state            <= adc_trig_pkg::st_idle;
      taken            <= '0;
      on_q             <= 1'b0;
      busy             <= 1'b0;
      irq              <= 1'b0;
      start            <= 1'b0;
      oor              <= 1'b0;
      result           <= '0;
    end else if (ce) begin
      control          <= next_control;
      timing           <= next_timing;
      high_limit_reg_a <= next_hia;
      high_limit_reg_b <= next_hib;
      low_limit_reg_a  <= next_loa;
      low_limit_reg_b  <= next_lob;
      rdata            <= next_rdata;
      state            <= next_state;
      taken            <= next_taken;
      on_q             <= next_on_q;
      busy             <= next_busy;
      irq              <= next_irq;
      start            <= next_start;
      oor              <= next_oor;
      result           <= next_result;
    end
  end

  assign conv_start        = start;
  assign host_irq          = irq;
  assign conversion_status = busy;

  ////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////
  chk_arm_rise: assert property (@(posedge clk) disable iff (!rstn)
    (ce && $rose(busy)) |->
      $past(cfg.on) && !$past(on_q))
    else $error("cycle began without enable rising");
  chk_lag_level: assert property (@(posedge clk) disable iff (!rstn)
    (ce && state == adc_trig_pkg::st_lag && tmr_exp && !pin_active) |=>
      !start)
    else $error("start issued at inactive level");
  chk_armed_wait: assert property (@(posedge clk) disable iff (!rstn)
    (ce && state == adc_trig_pkg::st_armed && cfg.ext && !edge_seen) |=>
      !start)
    else $error("external start without edge");
  chk_limit_stop: assert property (@(posedge clk) disable iff (!rstn)
    (ce && state == adc_trig_pkg::st_convert && conv_done &&
     conv_data > hi_lim) |=> irq && oor)
    else $error("limit break not flagged");
  chk_repeat_busy: assert property (@(posedge clk) disable iff (!rstn)
    (ce && state == adc_trig_pkg::st_done && cfg.repeat_on && !oor) |=>
      busy)
    else $error("repeat cycle dropped busy");
  chk_sync_pass: assert property (@(posedge clk) disable iff (!rstn)
    ce ##1 ce |-> sync_b == $past(sync_a))
    else $error("synchroniser skipped a stage");
  chk_gap_start: assert property (@(posedge clk) disable iff (!rstn)
    (ce && start) |-> $past(state) != adc_trig_pkg::st_convert)
    else $error("start right after conversion end");
  chk_done_idle: assert property (@(posedge clk) disable iff (!rstn)
    (ce && $fell(busy)) |-> state == adc_trig_pkg::st_idle)
    else $error("done without idle");

endmodule // adc_trigger_sequencer

// >>> core/interval_timer.sv
// Reloadable down counter for the trigger lag and sample gap.
// Assumes a single clock domain and a one-cycle load pulse.
`timescale 1ns/1ps
`include "adc_trig_regs.svh"

module interval_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  // Status
  output logic                  expired
);

  logic [WIDTH-1:0] remain;       // Cycles still to run
  logic [WIDTH-1:0] next_remain;
  logic             running;
  logic             next_running;

  // Next value: reload on every interval start
  always_comb begin
    next_remain  = remain;
    next_running = running;
    if (load) begin
      next_remain  = count;
      next_running = 1'b1;
    end else if (running) begin
      if (remain == '0) begin
        next_running = 1'b0;
      end else begin
        next_remain = remain - WIDTH'(1);
      end
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remain  <= '0;
      running <= 1'b0;
    end else if (ce) begin
      remain  <= next_remain;
      running <= next_running;
    end
  end

  // Expiry is the cycle the count reaches zero
  assign expired = running && (remain == '0) && !load;

endmodule // interval_timer

// >>> sim/conv_model.sv
// Behavioural converter engine facing the sequencer's start/done port.
// Assumes the sequencer's clock; latency and result come from the bench.
`timescale 1ns/1ps

module conv_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Sequencer side
  input  wire logic       conv_start,
  output logic            conv_done,
  output logic [9:0]      conv_data,
  // Bench side
  input  wire logic [4:0] lat,
  input  wire logic [9:0] sample_val
);
  logic [4:0] cnt;  // Cycles left in conversion
  logic       run;  // Conversion in flight
  logic [9:0] held; // Last result handed over

  ////////////////////////////////////////////////////////////////////////
  // Data shows the inverse of the last result outside done, so a late
  // sample in the sequencer never passes by luck
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt       <= 5'h00;
      run       <= 1'b0;
      held      <= 10'h000;
      conv_done <= 1'b0;
      conv_data <= 10'h3ff;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~held;
      if (conv_start && !run) begin // Accept a start
        run <= 1'b1;
        cnt <= lat;
      end else if (run && cnt == 5'h00) begin // Hand over the result
        run       <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= sample_val;
        held      <= sample_val;
      end else if (run) begin // Still converting
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule // conv_model

// >>> sim/testbench.sv
// Self-checking bench for the trigger sequencer and its engine model.
// Assumes conv_model is compiled first and a 25 MHz clock.
`timescale 1ns/1ps
`include "adc_trig_regs.svh"

module testbench;
  localparam logic [9:0] HI = 10'h200; // Upper limit
  localparam logic [9:0] LO = 10'h040; // Lower limit
  logic       clk, rstn, ce, wr, rd, pin, conv_start, conv_done;
  logic       host_irq, conversion_status;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic [9:0] conv_data, sample_val;
  logic [4:0] lat;
  logic [9:0] q[$]; // Results the engine will return, in order
  integer     seed;
  int failures, cmp_count, cyc, starts, base, done_cyc, last_st, gap_min;

  adc_trigger_sequencer dut_u (.clk(clk), .rstn(rstn), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .trigger_input_pin(pin), .conv_start(conv_start),
    .conv_done(conv_done), .conv_data(conv_data), .host_irq(host_irq),
    .conversion_status(conversion_status));
  conv_model conv_u (.clk(clk), .rstn(rstn), .conv_start(conv_start),
    .conv_done(conv_done), .conv_data(conv_data), .lat(lat),
    .sample_val(sample_val));

  always #20 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  // Start/done monitor; feeds the next queued result on each start
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (conv_start) begin
      if (starts != base && cyc - done_cyc < gap_min)
        gap_min = cyc - done_cyc;
      starts = starts + 1;
      last_st = cyc;
      sample_val <= (q.size() > 0) ? q.pop_front() : 10'h100;
    end
    if (conv_done) done_cyc = cyc;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (e !== g) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wreg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rreg(logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  // Bounded waits so a stuck sequencer cannot hang the run
  task automatic wait_start();
    for (int n = 0; n < 30000 && starts == base; n++) @(posedge clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (conversion_status !== 1'b0 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    chk("idle_in_time", 1, 32'(n < 30000));
    repeat (4) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // One cycle: model predicts sample count and limit flag from the queue
  task automatic run(logic [7:0] ctl, logic [7:0] tim, int bi,
                     logic [9:0] bv);
    logic [9:0] d[$];
    int n, e, t0, lg, gp, dl;
    logic oor, act;
    n   = (ctl[7:5] == 3'd0) ? 1 : (2 << ctl[7:5]);
    e   = n;
    oor = 1'b0;
    lg  = int'(tim[3:0]) * `STEP_CYCLES;
    gp  = int'(tim[7:4]) * `STEP_CYCLES;
    for (int i = 0; i < n; i++)
      d.push_back(LO + 10'($unsigned($random(seed)) % 449));
    if (n > 2) d[1] = LO;
    if (n > 2) d[2] = HI;
    if (bi < n) d[bi] = bv;
    foreach (d[i]) if (!oor && (d[i] > HI || d[i] < LO)) begin
      oor = 1'b1;
      e = i + 1;
    end
    q = d;
    base = starts;
    gap_min = 1 << 30;
    act = ctl[`CTL_EDGE];
    lat <= 5'(1 + $unsigned($random(seed)) % 16);
    pin <= ~act;
    wreg(`OFS_CONTROL, 8'h00);
    wreg(`OFS_TIMING, tim);
    wreg(`OFS_CONTROL, ctl);
    if (ctl[`CTL_EXT]) begin
      repeat (300) @(posedge clk);
      chk("armed_busy", 1, conversion_status);
      chk("armed_starts", base, starts);
      pin <= act;
      repeat (20) @(posedge clk);
      pin <= ~act;
      repeat (1500) @(posedge clk);
      chk("short_pulse_starts", base, starts);
      @(posedge clk);
      pin <= act;
      #1 t0 = cyc;
      wait_start();
      dl = last_st - t0;
      chk("lag_window", 1, 32'(dl >= lg && dl <= lg + 12));
      pin <= ~act;
      repeat (30) @(posedge clk);
      pin <= act;
      repeat (30) @(posedge clk);
      pin <= ~act;
    end
    wait_idle();
    chk("samples", e, starts - base);
    if (e > 1)
      chk("gap_window", 1, 32'(gap_min >= gp && gap_min <= gp + 12));
    chk("irq", 1, host_irq);
    rreg(`OFS_STATUS);
    chk("status", {29'h0, oor, 2'b10}, {24'h0, rv});
    chk("irq_cleared", 0, host_irq);
    if (n == 1) rreg(`OFS_RESULT);
    if (n == 1) chk("result", d[0][9:2], rv);
    wreg(`OFS_CONTROL, ctl);
    repeat (60) @(posedge clk);
    chk("no_restart", e, starts - base);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog at about two and a half times the expected run of some 23k cycles
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    summarize();
  end

  initial begin
    logic [3:0] ra[6];
    logic [7:0] re[6];
    int ok;
    ra = '{`OFS_CONTROL, `OFS_TIMING, `OFS_HIGH_A, `OFS_LOW_A, 4'h9,
           `OFS_STATUS};
    re = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    {clk, rstn, wr, rd, pin, addr, wdata} = '0;
    {cyc, starts, base, done_cyc, last_st, failures, cmp_count} = '0;
    ce = 1'b1;
    lat = 5'h04;
    sample_val = 10'h100;
    seed = 32'h2874;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    chk("irq_reset", 0, host_irq);
    for (int k = 0; k < 6; k++) begin
      rreg(ra[k]);
      chk("reset_value", re[k], rv);
    end
    $display("test reset values done");
    wreg(`OFS_HIGH_A, 8'h00);
    wreg(`OFS_HIGH_B, 8'h02);
    wreg(`OFS_LOW_A, 8'h40);
    wreg(`OFS_LOW_B, 8'h00);
    run(8'h01, 8'h00, 0, 10'h03f);
    run(8'h21, 8'h10, 99, 10'h000);
    run(8'h41, 8'h00, 3, 10'h201);
    run(8'he1, 8'h00, 99, 10'h000);
    $display("test internal trigger done");
    run(8'h27, 8'h11, 99, 10'h000);
    run(8'h23, 8'h11, 99, 10'h000);
    $display("test external trigger done");
    q = {};
    base = starts;
    pin <= 1'b0;
    wreg(`OFS_CONTROL, 8'h00);
    wreg(`OFS_TIMING, 8'h00);
    wreg(`OFS_CONTROL, 8'h2f);
    for (int k = 0; k < 4; k++) begin
      pin <= 1'b1;
      repeat (200) @(posedge clk);
      chk("holdoff_starts", k + 1, starts - base);
      pin <= 1'b0;
      repeat (20) @(posedge clk);
    end
    wait_idle();
    chk("holdoff_irq", 1, host_irq);
    rreg(`OFS_STATUS);
    $display("test holdoff done");
    base = starts;
    ok = 1;
    wreg(`OFS_CONTROL, 8'h00);
    wreg(`OFS_CONTROL, 8'h11);
    repeat (4) @(posedge clk);
    repeat (400) begin
      @(posedge clk);
      if (host_irq !== 1'b0 || conversion_status !== 1'b1) ok = 0;
    end
    chk("repeat_quiet", 1, ok);
    chk("repeat_restarts", 1, 32'(starts - base >= 5));
    wreg(`OFS_CONTROL, 8'h01);
    wait_idle();
    wreg(`OFS_CONTROL, 8'h00);
    rreg(`OFS_STATUS);
    q = {10'h100, 10'h100, 10'h3ff};
    base = starts;
    wreg(`OFS_CONTROL, 8'h11);
    wait_idle();
    chk("repeat_break_starts", 3, starts - base);
    chk("repeat_break_irq", 1, host_irq);
    rreg(`OFS_STATUS);
    chk("repeat_break_status", 8'h06, rv);
    // Leave repeat under external trigger: drop ext, then repeat, then on
    base = starts;
    wreg(`OFS_CONTROL, 8'h00);
    wreg(`OFS_CONTROL, 8'h17);
    repeat (100) @(posedge clk);
    chk("repeat_ext_wait", base, starts);
    wreg(`OFS_CONTROL, 8'h15);
    repeat (100) @(posedge clk);
    chk("repeat_int_runs", 1, 32'(starts - base >= 3));
    wreg(`OFS_CONTROL, 8'h05);
    wait_idle();
    chk("exit_irq", 1, host_irq);
    wreg(`OFS_CONTROL, 8'h00);
    rreg(`OFS_STATUS);
    chk("exit_status", 8'h02, rv);
    $display("test repeat done");
    summarize();
  end
endmodule // testbench
